// ### verilog/lcm_logic_cell.sv
`timescale 1ns/1ps
module lcm_logic_cell (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Data inputs from the cluster routing.
  input wire logic data_a,
  input wire logic data_b,
  input wire logic data_c,
  input wire logic fourth_table_input,
  input wire logic direct_register_input,
  // Register controls from the cluster routing.
  input wire logic cell_clk_en,
  input wire logic cell_clear,
  input wire logic cell_preset,
  // Chains from the neighbouring cell.
  input wire logic carry_in,
  input wire logic cascade_in,
  // Routing and chain outputs.
  output logic local_out,
  output logic global_out,
  output logic carry_out,
  output logic cascade_out
);

  logic [8:0] cfg;
  logic [15:0] lut_mask;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic rd_take;
  logic wr_take;
  logic [31:0] next_rdata;
  logic [31:0] status;
  lcm_pkg::lcm_mode_e mode;
  logic run;
  logic arith_like;
  logic fourth_sel;
  logic [3:0] idx4;
  logic [2:0] idx3;
  logic lut4_y;
  logic sum_y;
  logic carry_y;
  logic lut_res;
  logic cascaded;
  logic cnt_dir;
  logic cnt_en;
  logic cnt_load;
  logic reg_d;
  logic reg_ce;
  logic reg_q;

  // Bus slave: zero wait states, always OKAY, word transfers only.
  assign rd_take = hsel && htrans[1] && !hwrite && hready;
  assign wr_take = hsel && htrans[1] && hwrite && hready;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= wr_take;
      wr_addr <= {haddr[31:2], 2'b00};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb
  begin
    status = 32'h0000_0000;
    status[lcm_pkg::LCM_STAT_REG_Q] = reg_q;
    status[lcm_pkg::LCM_STAT_LOCAL] = local_out;
    status[lcm_pkg::LCM_STAT_GLOBAL] = global_out;
    status[lcm_pkg::LCM_STAT_CARRY] = carry_out;
    status[lcm_pkg::LCM_STAT_CASCADE] = cascade_out;
  end

  // Unmapped addresses read as zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if ({haddr[31:2], 2'b00} == lcm_pkg::LCM_CFG_OFFSET)
      next_rdata = {23'h00_0000, cfg};
    else if ({haddr[31:2], 2'b00} == lcm_pkg::LCM_MASK_OFFSET)
      next_rdata = {16'h0000, lut_mask};
    else if ({haddr[31:2], 2'b00} == lcm_pkg::LCM_STAT_OFFSET)
      next_rdata = status;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
      hrdata <= next_rdata;
  end

  // While the run bit is set only the run bit itself can be written, so
  // software cannot reshape the cell under a live clock.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg <= lcm_pkg::LCM_CFG_RESET;
    else if (wr_pend && wr_addr == lcm_pkg::LCM_CFG_OFFSET)
    begin
      if (cfg[lcm_pkg::LCM_CFG_RUN])
        cfg[lcm_pkg::LCM_CFG_RUN] <= hwdata[lcm_pkg::LCM_CFG_RUN];
      else
        cfg <= hwdata[lcm_pkg::LCM_CFG_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      lut_mask <= lcm_pkg::LCM_MASK_RESET;
    else if (wr_pend && wr_addr == lcm_pkg::LCM_MASK_OFFSET && !run)
      lut_mask <= hwdata[lcm_pkg::LCM_MASK_WIDTH-1:0];
  end

  assign mode = lcm_pkg::lcm_mode_e'(cfg[lcm_pkg::LCM_CFG_MODE_LSB +: 2]);
  assign run = cfg[lcm_pkg::LCM_CFG_RUN];
  assign arith_like = (mode == lcm_pkg::LCM_MODE_ARITH) ||
                      (mode == lcm_pkg::LCM_MODE_COUNTER);

  // Counter controls taken from the data inputs.
  assign cnt_dir = data_b;
  assign cnt_en = data_c;
  assign cnt_load = fourth_table_input;

  // In packed mode without the fourth input the table sees a constant
  // there, which leaves a three-input function in the low half of the mask.
  always_comb
  begin
    fourth_sel = 1'b0;
    unique case (mode)
      lcm_pkg::LCM_MODE_NORMAL:
        fourth_sel = cfg[lcm_pkg::LCM_CFG_CARRY_SEL] ?
                     carry_in : fourth_table_input;
      lcm_pkg::LCM_MODE_PACKED:
        fourth_sel = cfg[lcm_pkg::LCM_CFG_PACK_FOUR] ?
                     fourth_table_input : 1'b0;
      lcm_pkg::LCM_MODE_ARITH:
        fourth_sel = 1'b0;
      lcm_pkg::LCM_MODE_COUNTER:
        fourth_sel = 1'b0;
    endcase
  end

  assign idx4 = {fourth_sel, data_c, data_b, data_a};

  // Counter tables see register feedback in place of the first data input.
  assign idx3 = (mode == lcm_pkg::LCM_MODE_COUNTER) ?
                {carry_in, cnt_dir, reg_q} :
                {carry_in, data_b, data_a};

  lcm_lut #(
    .INPUTS(lcm_pkg::LCM_LUT4_INPUTS)
  ) u_lut4 (
    .mask(lut_mask),
    .index(idx4),
    .y(lut4_y)
  );

  lcm_lut #(
    .INPUTS(lcm_pkg::LCM_LUT3_INPUTS)
  ) u_lut_sum (
    .mask(lut_mask[lcm_pkg::LCM_HALF_WIDTH-1:0]),
    .index(idx3),
    .y(sum_y)
  );

  lcm_lut #(
    .INPUTS(lcm_pkg::LCM_LUT3_INPUTS)
  ) u_lut_carry (
    .mask(lut_mask[lcm_pkg::LCM_MASK_WIDTH-1:lcm_pkg::LCM_HALF_WIDTH]),
    .index(idx3),
    .y(carry_y)
  );

  assign lut_res = arith_like ? sum_y : lut4_y;

  // The cascade gate works the same in every mode, so it also runs next to
  // the carry chain in arithmetic mode.
  always_comb
  begin
    if (!cfg[lcm_pkg::LCM_CFG_CASC_EN])
      cascaded = lut_res;
    else if (cfg[lcm_pkg::LCM_CFG_CASC_OR])
      cascaded = lut_res || cascade_in;
    else
      cascaded = lut_res && cascade_in;
  end

  always_comb
  begin
    reg_d = cascaded;
    unique case (mode)
      lcm_pkg::LCM_MODE_NORMAL:
        reg_d = cascaded;
      lcm_pkg::LCM_MODE_PACKED:
        reg_d = cfg[lcm_pkg::LCM_CFG_PACK_FOUR] ?
                fourth_table_input : direct_register_input;
      lcm_pkg::LCM_MODE_ARITH:
        reg_d = cascaded;
      lcm_pkg::LCM_MODE_COUNTER:
        if (cnt_load)
          reg_d = direct_register_input;
        else
          reg_d = cnt_en ? sum_y : reg_q;
    endcase
  end

  // Clock enable, clear and preset reach the register in every mode.
  assign reg_ce = cell_clk_en && run;

  lcm_cell_reg u_reg (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(cell_clear),
    .preset(cell_preset),
    .clk_en(reg_ce),
    .d(reg_d),
    .q(reg_q)
  );

  // Outputs are staged one cycle so each leaves from a flip-flop; the
  // price is one extra cycle on every combinational path through the cell.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      local_out <= 1'b0;
      global_out <= 1'b0;
    end
    else
    begin
      local_out <= cfg[lcm_pkg::LCM_CFG_LOCAL_REG] ?
                   reg_q : cascaded;
      global_out <= cfg[lcm_pkg::LCM_CFG_GLOBAL_REG] ?
                    reg_q : cascaded;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      carry_out <= 1'b0;
      cascade_out <= 1'b0;
    end
    else
    begin
      carry_out <= arith_like ? carry_y : 1'b0;
      cascade_out <= cascaded;
    end
  end

  // Reference values for the checks below, built from the mask directly.
  logic exp_norm;
  logic exp_sum;
  logic exp_carry;
  logic quiet;
  assign exp_norm = lut_mask[{cfg[lcm_pkg::LCM_CFG_CARRY_SEL] ? carry_in :
                    fourth_table_input, data_c, data_b, data_a}];
  assign exp_sum = lut_mask[{1'b0, carry_in, data_b, data_a}];
  assign exp_carry = lut_mask[{1'b1, carry_in, data_b, data_a}];
  assign quiet = !cell_clear && !cell_preset;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_normal_table: assert property (
    (mode == lcm_pkg::LCM_MODE_NORMAL && !cfg[lcm_pkg::LCM_CFG_CASC_EN] &&
     !cfg[lcm_pkg::LCM_CFG_LOCAL_REG]) |=> local_out == $past(exp_norm))
    else $error("normal mode table output wrong");

  a_cascade_and: assert property (
    (cfg[lcm_pkg::LCM_CFG_CASC_EN] && !cfg[lcm_pkg::LCM_CFG_CASC_OR])
    |=> cascade_out == ($past(lut_res) && $past(cascade_in)))
    else $error("cascade gate wrong");

  a_route_both: assert property (
    (cfg[lcm_pkg::LCM_CFG_LOCAL_REG] == cfg[lcm_pkg::LCM_CFG_GLOBAL_REG])
    ##1 $stable(cfg) |-> local_out == global_out)
    else $error("local and global differ with same source");

  a_packed_direct: assert property (
    (mode == lcm_pkg::LCM_MODE_PACKED && !cfg[lcm_pkg::LCM_CFG_PACK_FOUR] &&
     reg_ce && quiet) ##1 quiet |-> reg_q == $past(direct_register_input))
    else $error("packed register missed direct input");

  a_packed_four: assert property (
    (mode == lcm_pkg::LCM_MODE_PACKED && cfg[lcm_pkg::LCM_CFG_PACK_FOUR] &&
     reg_ce && quiet) ##1 quiet |-> reg_q == $past(fourth_table_input))
    else $error("packed register missed shared input");

  a_packed_split: assert property (
    (mode == lcm_pkg::LCM_MODE_PACKED && !cfg[lcm_pkg::LCM_CFG_LOCAL_REG] &&
     cfg[lcm_pkg::LCM_CFG_GLOBAL_REG])
    |=> global_out == $past(reg_q) && local_out == $past(cascaded))
    else $error("packed output split wrong");

  a_arith_sum: assert property (
    (mode == lcm_pkg::LCM_MODE_ARITH && !cfg[lcm_pkg::LCM_CFG_CASC_EN] &&
     !cfg[lcm_pkg::LCM_CFG_LOCAL_REG]) |=> local_out == $past(exp_sum))
    else $error("arithmetic sum wrong");

  a_arith_carry: assert property (
    mode == lcm_pkg::LCM_MODE_ARITH |=> carry_out == $past(exp_carry))
    else $error("arithmetic carry wrong");

  a_counter_load: assert property (
    (mode == lcm_pkg::LCM_MODE_COUNTER && cnt_load && reg_ce && quiet)
    ##1 quiet |-> reg_q == $past(direct_register_input))
    else $error("counter load missed");

  a_counter_step: assert property (
    (mode == lcm_pkg::LCM_MODE_COUNTER && !cnt_load && cnt_en && reg_ce &&
     quiet) ##1 quiet |-> reg_q == $past(sum_y))
    else $error("counter step wrong");

  a_counter_hold: assert property (
    (mode == lcm_pkg::LCM_MODE_COUNTER && !cnt_load && !cnt_en && quiet)
    ##1 quiet |-> reg_q == $past(reg_q))
    else $error("counter moved while disabled");

  a_enable_hold: assert property (
    (!reg_ce && quiet) ##1 quiet |-> reg_q == $past(reg_q))
    else $error("register moved without clock enable");

  a_clear_wins: assert property (
    cell_clear |-> !reg_q)
    else $error("clear did not force zero");

  a_preset_sets: assert property (
    (cell_preset && !cell_clear) |-> reg_q)
    else $error("preset did not force one");

  a_config_frozen: assert property (
    (run && $past(run)) |-> $stable(cfg[lcm_pkg::LCM_CFG_RUN-1:0]) &&
    $stable(lut_mask))
    else $error("configuration changed while running");

  c_counter_count: cover property (
    mode == lcm_pkg::LCM_MODE_COUNTER && cnt_en && reg_ce ##1 carry_out);
  c_arith_cascade: cover property (
    mode == lcm_pkg::LCM_MODE_ARITH && cfg[lcm_pkg::LCM_CFG_CASC_EN] &&
    cascade_in ##1 cascade_out && carry_out);
  c_packed_split: cover property (
    mode == lcm_pkg::LCM_MODE_PACKED && local_out != global_out);
  c_preset_load: cover property (cell_preset ##1 reg_q);

endmodule

// ### verilog/lcm_pkg.sv
package lcm_pkg;

  // Operating modes of the cell, held in the low bits of the config word.
  typedef enum logic [1:0] {
    LCM_MODE_NORMAL,
    LCM_MODE_PACKED,
    LCM_MODE_ARITH,
    LCM_MODE_COUNTER
  } lcm_mode_e;

  // Byte addresses of the registers on the bus.
  localparam logic [31:0] LCM_CFG_OFFSET = 32'h0000_0000;
  localparam logic [31:0] LCM_MASK_OFFSET = 32'h0000_0004;
  localparam logic [31:0] LCM_STAT_OFFSET = 32'h0000_0008;

  // Config word field positions.
  localparam int LCM_CFG_MODE_LSB = 0;
  localparam int LCM_CFG_CARRY_SEL = 2;
  localparam int LCM_CFG_CASC_EN = 3;
  localparam int LCM_CFG_CASC_OR = 4;
  localparam int LCM_CFG_PACK_FOUR = 5;
  localparam int LCM_CFG_LOCAL_REG = 6;
  localparam int LCM_CFG_GLOBAL_REG = 7;
  localparam int LCM_CFG_RUN = 8;
  localparam int LCM_CFG_WIDTH = 9;

  // Status word field positions.
  localparam int LCM_STAT_REG_Q = 0;
  localparam int LCM_STAT_LOCAL = 1;
  localparam int LCM_STAT_GLOBAL = 2;
  localparam int LCM_STAT_CARRY = 3;
  localparam int LCM_STAT_CASCADE = 4;

  // Table sizes and the split of the mask into two three-input tables.
  localparam int LCM_LUT4_INPUTS = 4;
  localparam int LCM_LUT3_INPUTS = 3;
  localparam int LCM_MASK_WIDTH = 16;
  localparam int LCM_HALF_WIDTH = 8;

  // Values after reset.
  localparam logic [8:0] LCM_CFG_RESET = 9'h000;
  localparam logic [15:0] LCM_MASK_RESET = 16'h0000;

endpackage

// ### verilog/lcm_lut.sv
`timescale 1ns/1ps
module lcm_lut #(
  parameter int INPUTS = 3
) (
  // Truth table, one bit per input combination.
  input wire logic [(2**INPUTS)-1:0] mask,
  // Table inputs.
  input wire logic [INPUTS-1:0] index,
  // Table output.
  output logic y
);

  always_comb
  begin
    y = mask[index];
  end

endmodule

// ### verilog/lcm_cell_reg.sv
`timescale 1ns/1ps
module lcm_cell_reg (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Asynchronous loads, active high.
  input wire logic clear,
  input wire logic preset,
  // Synchronous path.
  input wire logic clk_en,
  input wire logic d,
  // Register output.
  output logic q
);

  logic async_clr;
  logic async_pre;

  // Clear wins over preset so that a stuck preset cannot mask a reset.
  assign async_clr = !reset_n || clear;
  assign async_pre = preset && !async_clr;

  always_ff @(posedge core_clk or posedge async_clr or posedge async_pre)
  begin
    if (async_clr)
      q <= 1'b0;
    else if (async_pre)
      q <= 1'b1;
    else if (clk_en)
      q <= d;
  end

endmodule

// ### bench/lcm_chain_model.sv
`timescale 1ns/1ps
module lcm_chain_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Values the neighbour is told to present next.
  input wire logic next_carry,
  input wire logic next_cascade,
  // Chain outputs toward the cell under test.
  output logic carry_in,
  output logic cascade_in
);
  // The neighbour is a registered cell, so its chain outputs move only
  // after a rising edge and sit low while it is held in reset.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      carry_in <= 1'b0;
      cascade_in <= 1'b0;
    end
    else
    begin
      carry_in <= next_carry;
      cascade_in <= next_cascade;
    end
  end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Steps of clear, preset, enable and data, with the register expected.
  localparam logic [4:0] REG_STEPS [5] = '{5'h12, 5'h09, 5'h01, 5'h1a, 5'h07};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic a = 1'b0, b = 1'b0, c = 1'b0, d3 = 1'b0, dr = 1'b0;
  logic ce = 1'b0, clr = 1'b0, pre = 1'b0, nc = 1'b0, ns = 1'b0;
  logic cin, casc, lo, go, co, so;
  logic strobe = 1'b0;
  logic rd_ph = 1'b0;
  logic [63:0] notes [$];
  logic [31:0] st = 32'h0000_08c7;
  logic [15:0] m;
  logic [8:0] cf;
  logic [3:0] ex;
  logic q, l;
  int failures = 0;
  int total_checks = 0;

  always #10 core_clk = ~core_clk;

  lcm_logic_cell i_lcm_logic_cell (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .data_a(a), .data_b(b), .data_c(c), .fourth_table_input(d3),
    .direct_register_input(dr), .cell_clk_en(ce), .cell_clear(clr),
    .cell_preset(pre), .carry_in(cin), .cascade_in(casc),
    .local_out(lo), .global_out(go), .carry_out(co), .cascade_out(so)
  );

  lcm_chain_model i_lcm_chain_model (
    .core_clk(core_clk), .reset_n(reset_n), .next_carry(nc),
    .next_cascade(ns), .carry_in(cin), .cascade_in(casc)
  );

  function logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task note(input logic [31:0] care, input logic [31:0] exp);
    notes.push_back({care, exp});
  endtask

  task ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask

  task rd(input logic [31:0] ad, input logic [31:0] exp);
    note(32'hffff_ffff, exp);
    ahb(1'b0, ad, 32'h0000_0000);
  endtask

  // Writing zero first drops the run bit, which unlocks the other fields.
  task setup(input logic [8:0] v);
    ahb(1'b1, lcm_pkg::LCM_CFG_OFFSET, 32'h0000_0000);
    ahb(1'b1, lcm_pkg::LCM_MASK_OFFSET, {16'h0000, m});
    ahb(1'b1, lcm_pkg::LCM_CFG_OFFSET, {23'h00_0000, v});
  endtask

  task put(input logic [9:0] v);
    @(posedge core_clk);
    {a, b, c, d3, dr, ce, clr, pre, nc, ns} <= v;
  endtask

  // Four edges cover the neighbour, the register and the output stage.
  task look(input logic [3:0] care, input logic [3:0] e);
    repeat (4) @(posedge core_clk);
    note({28'h000_0000, care}, {28'h000_0000, e});
    strobe <= 1'b1;
    @(posedge core_clk);
    strobe <= 1'b0;
  endtask

  always @(posedge core_clk)
  begin
    logic [63:0] n;
    if (strobe || (rd_ph && hready))
    begin
      n = notes.pop_front();
      check((strobe ? {28'h000_0000, lo, go, co, so} : hrdata) & n[63:32],
        n[31:0] & n[63:32]);
    end
    if (rd_ph && hready)
      check({31'h0000_0000, hresp}, 32'h0000_0000);
    if (hready)
      rd_ph <= htrans[1] && !hwrite;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    summarize;
  end

  initial
  begin
    logic [31:0] r;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(lcm_pkg::LCM_CFG_OFFSET, 32'h0000_0000);
    rd(lcm_pkg::LCM_MASK_OFFSET, 32'h0000_0000);
    rd(lcm_pkg::LCM_STAT_OFFSET, 32'h0000_0000);
    rd(32'h0000_000c, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      r = xs();
      m = r[15:0];
      r = xs();
      cf = {3'b110, 1'b0, r[3:1], r[0], 1'b0};
      setup(cf);
      put({r[9:5], 3'b100, r[11:10]});
      if (r[0])
        l = m[{1'b0, r[11], r[8], r[9]}];
      else
        l = m[{r[1] ? r[11] : r[6], r[7], r[8], r[9]}];
      ex = {l, l, r[0] & m[{1'b1, r[11], r[8], r[9]}], 1'b0};
      ex[0] = r[3] ? (l | r[10]) : (l & r[10]);
      look({!r[2], !r[2], 1'b1, r[2]}, ex);
    end
    for (int i = 0; i < 10; i++)
    begin
      r = xs();
      m = r[15:0];
      r = xs();
      cf = {1'b1, !r[0], r[0], r[1], 3'b000, 2'b01};
      setup(cf);
      put({r[9:5], 3'b100, r[11:10]});
      l = m[{r[1] & r[6], r[7], r[8], r[9]}];
      q = r[1] ? r[6] : r[5];
      ex = {r[0] ? q : l, r[0] ? l : q, 2'b00};
      look(4'b1110, ex);
    end
    setup(9'h181);
    foreach (REG_STEPS[i])
    begin
      put({4'b0000, REG_STEPS[i][1], REG_STEPS[i][2], REG_STEPS[i][4],
        REG_STEPS[i][3], 2'b00});
      look(4'b0100, {1'b0, REG_STEPS[i][0], 2'b00});
    end
    r = xs();
    m = r[15:0];
    setup(9'h1c3);
    put(10'h008);
    q = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      r = xs();
      put({1'b0, r[1], r[0], r[2], r[3], 3'b000, r[4], 1'b0});
      repeat (2) @(posedge core_clk);
      ce <= 1'b1;
      @(posedge core_clk);
      ce <= 1'b0;
      q = r[2] ? r[3] : (r[0] ? m[{1'b0, r[4], r[1], q}] : q);
      ex = {q, q, m[{1'b1, r[4], r[1], q}], 1'b0};
      look(4'b1110, ex);
    end
    ahb(1'b1, lcm_pkg::LCM_CFG_OFFSET, 32'h0000_0100);
    ahb(1'b1, lcm_pkg::LCM_MASK_OFFSET, {16'h0000, ~m});
    rd(lcm_pkg::LCM_CFG_OFFSET, 32'h0000_01c3);
    rd(lcm_pkg::LCM_MASK_OFFSET, {16'h0000, m});
    l = m[{1'b0, r[4], r[1], q}];
    ex = {m[{1'b1, r[4], r[1], q}], q, q, q};
    rd(lcm_pkg::LCM_STAT_OFFSET, {27'h000_0000, l, ex});
    summarize;
  end
endmodule
